// [logic/uoe_out_endpoint.sv]
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
// Behaviour
// - Writing 1 to control-low bit 7 resets the OUT data toggle and the bit reads 0.
// - The stall-sent flag at bit 6 is set each time a STALL handshake is sent.
// - While send-stall at bit 5 is 1, every OUT request is answered with STALL.
// - Writing 1 to flush at bit 4 resets the FIFO pointer and clears packet ready.
// - The flush bit returns to 0 by itself once the flush has finished.
// - The data-error flag at bit 3 sets with packet ready on a CRC or stuffing error.
// - The data-error flag only carries meaning in isochronous mode.
// - The overrun flag at bit 2 is set when a packet is lost to a full FIFO.
// - With double buffering, the full flag at bit 1 reads 1 when two packets are held.
// - Without double buffering, the full flag reads 1 when one packet is held.
// - Packet ready at bit 0 is set when a received packet is available.
// - The length of the current packet is a 10-bit count over two registers.
// - With a second packet waiting, packet ready sets again after firmware clears it.
// - Each generated STALL raises an endpoint interrupt.
module uoe_out_endpoint #(
    parameter int COUNT_W = uoe_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [uoe_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Packet engine side
    input wire logic out_token,
    input wire logic pkt_done,
    input wire logic pkt_crc_error,
    input wire logic [COUNT_W-1:0] pkt_len,
    output logic stall_reply,
    output logic ack_reply,
    output logic data_toggle,
    output logic fifo_ptr_reset,
    output logic irq
);
    import uoe_pkg::*;

    if (COUNT_W != 10) begin : g_bad_width
        $error("uoe_out_endpoint: count registers hold exactly 10 bits");
    end

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic stall_sent_flag;
    logic send_stall_request;
    logic flush_busy;
    logic packet_error_flag;
    logic overrun_flag;
    logic out_buffer_full;
    logic out_packet_ready;
    logic out_double_buffer_enable;
    logic iso_enable;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [1:0] flush_cnt;
    logic [1:0] used;
    logic [COUNT_W-1:0] head_len;
    logic [7:0] out_count_low;
    logic [1:0] out_count_high;
    logic [INT_W-1:0] int_events;
    // Count follows the store head; reads 0 while no packet is ready
    assign out_count_low = out_packet_ready ? head_len[7:0] : 8'h00;
    assign out_count_high = out_packet_ready ? head_len[9:8] : 2'h0;

    // Accesses complete in the cycle after they are seen: waitrequest
    // drops for one cycle, which also keeps read side effects single.
    logic access;
    logic bus_done;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;

    assign access = (avs_read || avs_write) && !bus_done;
    assign wr_fire = avs_write && bus_done;
    assign rd_fire = avs_read && bus_done;
    assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : RESET_BYTE;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_low;
    logic wr_high;
    logic wr_mask;
    assign wr_low = wr_fire && avs_byteenable[0] && hit(avs_address, OFF_CTRL_LOW);
    assign wr_high = wr_fire && avs_byteenable[0] && hit(avs_address, OFF_CTRL_HIGH);
    assign wr_mask = wr_fire && avs_byteenable[0] && hit(avs_address, OFF_INT_MASK);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_done <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_done <= access;
            avs_waitrequest <= !access;
        end
    end

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = RESET_BYTE;
        unique case (avs_address)
            OFF_CTRL_LOW: begin
                // Clear-toggle is write-only and always reads 0
                next_rdata = {1'b0, stall_sent_flag, send_stall_request, flush_busy,
                              packet_error_flag, overrun_flag, out_buffer_full,
                              out_packet_ready};
            end
            OFF_CTRL_HIGH: next_rdata = {out_double_buffer_enable, iso_enable, 6'h00};
            OFF_COUNT_LOW: next_rdata = out_count_low;
            OFF_COUNT_HIGH: next_rdata = {6'h00, out_count_high};
            // Events landing at the capture edge are shown before the clear
            OFF_INT_STATUS: next_rdata = {5'h00, int_status | int_events};
            OFF_INT_MASK: next_rdata = {5'h00, int_mask};
            default: next_rdata = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= 32'h0;
        end else if (access && avs_read) begin
            avs_readdata <= {24'h000000, next_rdata};
        end
    end

    // ----------------------------------------------------------------
    // Configuration
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_double_buffer_enable <= 1'b0;
            iso_enable <= 1'b0;
            int_mask <= RESET_INT_MASK;
            send_stall_request <= 1'b0;
        end else begin
            if (wr_high) begin
                out_double_buffer_enable <= wbyte[B_DOUBLE_BUF];
                iso_enable <= wbyte[B_ISO];
            end
            if (wr_mask) begin
                int_mask <= wbyte[INT_W-1:0];
            end
            if (wr_low) begin
                send_stall_request <= wbyte[B_SEND_STALL];
            end
        end
    end

    // ----------------------------------------------------------------
    // Data toggle
    // ----------------------------------------------------------------
    logic take_pkt;
    logic drop_pkt;
    logic stall_now;
    assign stall_now = out_token && send_stall_request;
    // A packet is lost when no slot is free for it
    assign take_pkt = pkt_done && !send_stall_request && !flush_busy && !out_buffer_full;
    assign drop_pkt = pkt_done && !send_stall_request && !flush_busy && out_buffer_full;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            data_toggle <= 1'b0;
        end else if (wr_low && wbyte[B_CLEAR_TOGGLE]) begin
            data_toggle <= 1'b0;
        end else if (take_pkt && (!pkt_crc_error || iso_enable)) begin
            data_toggle <= ~data_toggle;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stall_reply <= 1'b0;
            ack_reply <= 1'b0;
        end else begin
            stall_reply <= stall_now;
            ack_reply <= take_pkt && !iso_enable && !pkt_crc_error;
        end
    end

    // ----------------------------------------------------------------
    // Flush
    // ----------------------------------------------------------------
    // Held a fixed few cycles so the packet engine sees the pointer reset
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flush_busy <= 1'b0;
            flush_cnt <= 2'h0;
            fifo_ptr_reset <= 1'b0;
        end else if (wr_low && wbyte[B_FLUSH]) begin
            flush_busy <= 1'b1;
            flush_cnt <= 2'(FLUSH_CYCLES - 1);
            fifo_ptr_reset <= 1'b1;
        end else if (flush_busy) begin
            if (flush_cnt == 2'h0) begin
                flush_busy <= 1'b0;
                fifo_ptr_reset <= 1'b0;
            end else begin
                flush_cnt <= 2'(flush_cnt - 2'h1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Packet slots
    // ----------------------------------------------------------------
    logic fw_release;
    logic flush_start;
    assign flush_start = wr_low && wbyte[B_FLUSH];
    // Firmware frees a slot by writing packet ready as 0 while it is set
    assign fw_release = wr_low && !wbyte[B_PKT_READY] && out_packet_ready
                        && !flush_start;

    uoe_slot_store #(
        .COUNT_W(COUNT_W)
    ) u_slots (
        .clk(clk),
        .rst_n(rst_sync_n),
        .clear(flush_start),
        .push(take_pkt),
        .push_len(pkt_len),
        .pop(fw_release),
        .used(used),
        .head_len(head_len)
    );

    logic [1:0] next_used;
    assign next_used = flush_start ? 2'h0
                     : 2'(used + {1'b0, take_pkt} - {1'b0, fw_release});

    logic err_slot0;
    logic err_slot1;
    logic err_rd;
    logic err_wr;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_slot0 <= 1'b0;
            err_slot1 <= 1'b0;
            err_rd <= 1'b0;
            err_wr <= 1'b0;
        end else if (flush_start) begin
            err_rd <= 1'b0;
            err_wr <= 1'b0;
        end else begin
            if (take_pkt) begin
                if (err_wr) begin
                    err_slot1 <= pkt_crc_error;
                end else begin
                    err_slot0 <= pkt_crc_error;
                end
                err_wr <= ~err_wr;
            end
            if (fw_release) begin
                err_rd <= ~err_rd;
            end
        end
    end

    logic next_err;
    logic next_rd;
    assign next_rd = fw_release ? ~err_rd : err_rd;
    always_comb begin
        if (used == 2'h0 || (used == 2'h1 && fw_release)) begin
            next_err = pkt_crc_error; // the arriving packet becomes current
        end else begin
            next_err = next_rd ? err_slot1 : err_slot0;
        end
    end

    // Packet ready, error, full and counts track the current slot
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_packet_ready <= 1'b0;
            packet_error_flag <= 1'b0;
            out_buffer_full <= 1'b0;
        end else begin
            out_packet_ready <= (next_used != 2'h0);
            // Valid in isochronous mode only; cleared with packet ready
            packet_error_flag <= (next_used != 2'h0) && next_err;
            out_buffer_full <= out_double_buffer_enable ? (next_used == 2'h2)
                             : (next_used != 2'h0);
        end
    end

    // ----------------------------------------------------------------
    // Stall-sent and overrun
    // ----------------------------------------------------------------
    // Hardware set wins over a firmware clear in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stall_sent_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (stall_now) begin
                stall_sent_flag <= 1'b1;
            end else if (wr_low && !wbyte[B_STALL_SENT]) begin
                stall_sent_flag <= 1'b0;
            end
            if (drop_pkt) begin
                overrun_flag <= 1'b1;
            end else if (wr_low && !wbyte[B_OVERRUN]) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic rd_status;
    logic pr_rise;
    assign pr_rise = (next_used != 2'h0) && (!out_packet_ready || fw_release);
    assign int_events = {drop_pkt, stall_now, pr_rise};
    assign rd_status = rd_fire && hit(avs_address, OFF_INT_STATUS);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_status <= {INT_W{1'b0}};
            irq <= 1'b0;
        end else begin
            // Events in the read cycle survive the read clear
            int_status <= (rd_status ? {INT_W{1'b0}} : int_status) | int_events;
            irq <= |(((rd_status ? {INT_W{1'b0}} : int_status) | int_events) & int_mask);
        end
    end
endmodule : uoe_out_endpoint

// [common/uoe_pkg.sv]
package uoe_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses, one byte each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL_LOW = 8'h14;
    localparam logic [7:0] OFF_CTRL_HIGH = 8'h15;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h16;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h17;
    localparam logic [7:0] OFF_INT_STATUS = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h19;
    // ----------------------------------------------------------------
    // Control low bit positions
    // ----------------------------------------------------------------
    localparam int B_CLEAR_TOGGLE = 7;
    localparam int B_STALL_SENT = 6;
    localparam int B_SEND_STALL = 5;
    localparam int B_FLUSH = 4;
    localparam int B_PKT_ERROR = 3;
    localparam int B_OVERRUN = 2;
    localparam int B_BUF_FULL = 1;
    localparam int B_PKT_READY = 0;
    // Control high bit positions
    localparam int B_DOUBLE_BUF = 7;
    localparam int B_ISO = 6;
    // Interrupt status bit positions
    localparam int I_PKT_READY = 0;
    localparam int I_STALL = 1;
    localparam int I_OVERRUN = 2;
    localparam int INT_W = 3;
    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int COUNT_W = 10;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESET_INT_MASK = 3'h0;
    localparam int FLUSH_CYCLES = 2;
endpackage : uoe_pkg

// [logic/uoe_slot_store.sv]
`timescale 1ns/1ns
// Two-slot store of received packet lengths; models packet occupancy
module uoe_slot_store #(
    parameter int COUNT_W = uoe_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic push,
    input wire logic [COUNT_W-1:0] push_len,
    input wire logic pop,
    output logic [1:0] used,
    output logic [COUNT_W-1:0] head_len
);
    import uoe_pkg::*;

    logic [COUNT_W-1:0] lens [2];
    logic rd_ptr;
    logic wr_ptr;

    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_width
        $error("uoe_slot_store: COUNT_W out of range");
    end

    assign head_len = lens[rd_ptr];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            used <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else if (clear) begin
            used <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            used <= 2'(used + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            lens[wr_ptr] <= push_len;
        end
    end
endmodule : uoe_slot_store

// [test/uoe_out_endpoint_props.sv]
`timescale 1ns/1ns
module uoe_out_endpoint_props #(
    parameter int COUNT_W = uoe_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [uoe_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic out_token,
    input wire logic pkt_done,
    input wire logic pkt_crc_error,
    input wire logic [COUNT_W-1:0] pkt_len,
    input wire logic stall_reply,
    input wire logic ack_reply,
    input wire logic data_toggle,
    input wire logic fifo_ptr_reset,
    input wire logic irq
);
    import uoe_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Register access and flush sequences
    // ----
    sequence s_ctrl_wr;
        !avs_waitrequest && avs_write && avs_address == OFF_CTRL_LOW && avs_byteenable[0];
    endsequence
    sequence s_flush;
        fifo_ptr_reset ##[1:4] !fifo_ptr_reset;
    endsequence
    a_wait_one_cycle: assert property (avs_waitrequest && (avs_read || avs_write)
        |=> !avs_waitrequest) else $error("access not answered in one cycle");
    a_wait_one_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_needs_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_upper_bytes_zero: assert property (!avs_waitrequest && avs_read
        |-> avs_readdata[31:8] == 24'h0) else $error("upper read bytes not zero");
    a_stall_after_token: assert property (stall_reply |-> $past(out_token))
        else $error("stall without token");
    a_stall_not_ack: assert property (stall_reply |-> !ack_reply)
        else $error("stall and ack together");
    a_toggle_clear: assert property (s_ctrl_wr ##0 avs_writedata[7] |=> !data_toggle)
        else $error("toggle not cleared");
    a_toggle_reads_zero: assert property (!avs_waitrequest && avs_read &&
        avs_address == OFF_CTRL_LOW |-> !avs_readdata[7]) else $error("bit 7 read as one");
    a_flush_start: assert property (s_ctrl_wr ##0 avs_writedata[4]
        |-> ##[0:2] fifo_ptr_reset) else $error("flush did not start");
    a_flush_ends: assert property ($rose(fifo_ptr_reset) |-> s_flush)
        else $error("flush did not end");
    a_ack_after_pkt: assert property (ack_reply |-> $past(pkt_done) || $past(pkt_done, 2))
        else $error("ack without packet");
endmodule : uoe_out_endpoint_props
bind uoe_out_endpoint uoe_out_endpoint_props #(.COUNT_W(COUNT_W)) chk_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .out_token(out_token),
    .pkt_done(pkt_done), .pkt_crc_error(pkt_crc_error), .pkt_len(pkt_len),
    .stall_reply(stall_reply), .ack_reply(ack_reply), .data_toggle(data_toggle),
    .fifo_ptr_reset(fifo_ptr_reset), .irq(irq)
);

// [test/uoe_host_model.sv]
`timescale 1ns/1ns
module uoe_host_model #(
    parameter int COUNT_W = uoe_pkg::COUNT_W
) (
    input wire logic clk,
    output logic out_token,
    output logic pkt_done,
    output logic pkt_crc_error,
    output logic [COUNT_W-1:0] pkt_len
);
    initial begin
        out_token = 1'b0;
        pkt_done = 1'b0;
        pkt_crc_error = 1'b0;
        pkt_len = '1;
    end
    // ----
    // Token, gap cycles of host delay, then the data packet
    // ----
    task automatic send(input logic [COUNT_W-1:0] len, input logic crc, input int gap);
        @(posedge clk);
        out_token <= 1'b1;
        @(posedge clk);
        out_token <= 1'b0;
        repeat (gap) @(posedge clk);
        pkt_done <= 1'b1;
        pkt_crc_error <= crc;
        pkt_len <= len;
        @(posedge clk);
        pkt_done <= 1'b0;
        pkt_crc_error <= ~crc;
        // Stale length inverted so a late sample cannot pass for the real one
        pkt_len <= ~len;
    endtask : send
endmodule : uoe_host_model

// [test/usb_out_endpoint_control_status_tb_top.sv]
`timescale 1ns/1ns
module usb_out_endpoint_control_status_tb_top;
    import uoe_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic out_token, pkt_done, pkt_crc_error, stall_reply, ack_reply, data_toggle;
    logic [COUNT_W-1:0] pkt_len;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int pq[$];
    int n_stall = 0;
    int n_ack = 0;
    int n_stall_exp = 0;
    int n_ack_exp = 0;
    bit dbl, iso, st_sent, sstall, ovr, perr, tog;
    logic [2:0] ist = 3'h0;
    logic [2:0] msk = 3'h0;
    logic [31:0] seed = 32'ha3d1;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    uoe_out_endpoint dut_u (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .out_token(out_token),
        .pkt_done(pkt_done), .pkt_crc_error(pkt_crc_error), .pkt_len(pkt_len),
        .stall_reply(stall_reply), .ack_reply(ack_reply), .data_toggle(data_toggle),
        .fifo_ptr_reset(), .irq(irq)
    );
    uoe_host_model host_u (.clk(clk), .out_token(out_token), .pkt_done(pkt_done),
        .pkt_crc_error(pkt_crc_error), .pkt_len(pkt_len));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stall_reply === 1'b1) n_stall <= n_stall + 1;
        if (ack_reply === 1'b1) n_ack <= n_ack + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_sim();
        end
    end
    // ----
    // Helpers and reference model
    // ----
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic end_sim();
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] be, output logic [31:0] r);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    function automatic logic [7:0] rexp(input logic [7:0] a);
        logic full;
        full = pq.size() >= (dbl ? 2 : 1);
        case (a)
            OFF_CTRL_LOW: return {1'b0, st_sent, sstall, 1'b0, perr, ovr, full, pq.size() > 0};
            OFF_CTRL_HIGH: return {dbl, iso, 6'h0};
            OFF_COUNT_LOW: return (pq.size() > 0) ? pq[0][7:0] : 8'h00;
            OFF_COUNT_HIGH: return (pq.size() > 0) ? {6'h0, pq[0][9:8]} : 8'h00;
            OFF_INT_STATUS: return {5'h0, ist};
            OFF_INT_MASK: return {5'h0, msk};
            default: return 8'h00;
        endcase
    endfunction : rexp
    task automatic rreg(input logic [7:0] a);
        logic [31:0] r;
        logic [7:0] e;
        e = rexp(a);
        bus(1'b0, a, 8'h00, 4'hf, r);
        chk(r, {24'h0, e});
        if (a == OFF_INT_STATUS) ist = 3'h0;
        repeat (2) @(posedge clk);
        chk(irq, |(ist & msk));
    endtask : rreg
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 4'h1, r);
        if (a == OFF_CTRL_HIGH) {dbl, iso} = d[7:6];
        if (a == OFF_INT_MASK) msk = d[2:0];
        if (a == OFF_CTRL_LOW) begin
            if (d[7]) tog = 1'b0;
            if (!d[6]) st_sent = 1'b0;
            sstall = d[5];
            if (!d[2]) ovr = 1'b0;
            if (d[4] || (!d[0] && pq.size() > 0)) perr = 1'b0;
            if (d[4]) begin
                pq.delete();
            end else if (!d[0] && pq.size() > 0) begin
                void'(pq.pop_front());
                if (pq.size() > 0) ist[I_PKT_READY] = 1'b1;
            end
        end
    endtask : wreg
    task automatic pkt(input logic crc, input int gap);
        logic [31:0] r;
        r = xs();
        host_u.send(r[COUNT_W-1:0], crc, gap);
        if (sstall) begin
            st_sent = 1'b1;
            ist[I_STALL] = 1'b1;
            n_stall_exp++;
        end else if (pq.size() >= (dbl ? 2 : 1)) begin
            ovr = 1'b1;
            ist[I_OVERRUN] = 1'b1;
        end else begin
            if (pq.size() == 0) {ist[I_PKT_READY], perr} = {1'b1, crc};
            pq.push_back(int'(r[COUNT_W-1:0]));
            // Toggle also advances on accepted isochronous packets
            if (!crc || iso) tog = !tog;
            if (!iso && !crc) n_ack_exp++;
        end
        repeat (3) @(posedge clk);
        chk(data_toggle, tog);
        chk(n_stall, n_stall_exp);
        chk(n_ack, n_ack_exp);
    endtask : pkt
    // ----
    // Main sequence
    // ----
    initial begin
        logic [31:0] r;
        {avs_read, avs_write, avs_writedata, avs_byteenable, avs_address} = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 'h14; a <= 'h19; a++) rreg(8'(a));
        wreg(8'h30, 8'hff);
        rreg(8'h30);
        pkt(1'b0, 1);
        rreg(OFF_CTRL_LOW);
        rreg(OFF_COUNT_LOW);
        rreg(OFF_COUNT_HIGH);
        wreg(OFF_INT_MASK, 8'h07);
        rreg(OFF_INT_MASK);
        pkt(1'b0, 6);
        rreg(OFF_INT_STATUS);
        wreg(OFF_CTRL_LOW, 8'h04);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_LOW, 8'h00);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_HIGH, 8'h80);
        pkt(1'b0, 0);
        pkt(1'b0, 3);
        rreg(OFF_CTRL_LOW);
        rreg(OFF_INT_STATUS);
        wreg(OFF_CTRL_LOW, 8'h00);
        rreg(OFF_INT_STATUS);
        rreg(OFF_COUNT_LOW);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_LOW, 8'h00);
        wreg(OFF_CTRL_HIGH, 8'h40);
        pkt(1'b1, 2);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_LOW, 8'h00);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_HIGH, 8'h00);
        wreg(OFF_CTRL_LOW, 8'h20);
        pkt(1'b0, 2);
        rreg(OFF_CTRL_LOW);
        rreg(OFF_INT_STATUS);
        wreg(OFF_CTRL_LOW, 8'h40);
        pkt(1'b0, 1);
        bus(1'b1, OFF_CTRL_LOW, 8'h20, 4'h0, r);
        rreg(OFF_CTRL_LOW);
        wreg(OFF_CTRL_LOW, 8'h40);
        wreg(OFF_CTRL_LOW, 8'h00);
        pkt(1'b0, 1);
        wreg(OFF_CTRL_LOW, 8'h11);
        repeat (FLUSH_CYCLES + 2) @(posedge clk);
        rreg(OFF_CTRL_LOW);
        pkt(1'b0, 1);
        wreg(OFF_CTRL_LOW, 8'h80);
        @(posedge clk);
        chk(data_toggle, tog);
        rreg(OFF_CTRL_LOW);
        end_sim();
    end
endmodule : usb_out_endpoint_control_status_tb_top
